// ==== verilog/sid_dispatch.sv ====
// sewing input dispatch: pin decode, counters, fixed-angle cycle and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps

module sid_dispatch
  import sid_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire sid_pins_t             pins,
  output sid_cmd_t                   cmd,
  input  wire logic [SID_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [SID_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [SID_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [SID_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int unsigned PW = $bits(sid_pins_t);

  logic [PW-1:0]         meta_r;
  logic [PW-1:0]         sync_r;
  logic [PW-1:0]         prev_r;
  sid_pins_t             lvl;
  sid_pins_t             rise;
  logic                  fault_r;
  logic                  op_ok;
  logic [1:0]            mode_r;
  logic [SID_CNT_W-1:0]  up_cnt_r;
  logic [SID_CNT_W-1:0]  dn_cnt_r;
  sid_fa_state_t         fa_state_r;
  logic [1:0]            fa_phase_r;
  logic                  msg_r;
  logic                  foot_down_r;
  logic                  start_req;
  logic                  start_blocked;
  logic                  sw_jog_ok;
  logic                  wr_jog_fwd;
  logic                  wr_jog_bwd;

  // axi state
  logic                  aw_ok_r;
  logic                  w_ok_r;
  logic [SID_ADDR_W-1:0] wr_addr_r;
  logic [SID_DATA_W-1:0] wr_data_r;
  logic [3:0]            wr_strb_r;
  logic                  wr_fire;
  logic                  wr_mapped;
  logic                  rd_mapped;
  logic [SID_DATA_W-1:0] rd_data;

  // two-stage synchroniser per input line
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= pins[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  assign lvl  = sid_pins_t'(sync_r);
  assign rise = sid_pins_t'(sync_r & ~prev_r);

  // fault latch; only a reset (power cycle) releases it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_r <= 1'b0;
    else if (lvl.pressure_low_in)
      fault_r <= 1'b1;
  end

  // the pressure level itself also blocks, so the cycle it rises already does nothing
  assign op_ok = !fault_r && !lvl.pressure_low_in && !lvl.global_inhibit_in;

  assign start_blocked = !lvl.clamp_on_in || lvl.start_inhibit_in || lvl.machine_running_in;
  assign start_req     = rise.start_in && op_ok && !start_blocked;

  // up counter: any clear beats counting, opposite steps in one cycle cancel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      up_cnt_r <= '0;
    else if (op_ok)
    begin
      if (rise.counters_clear_in || rise.up_count_clear_in)
        up_cnt_r <= '0;
      else if (rise.up_count_increment_in && !rise.up_count_decrement_in)
        up_cnt_r <= up_cnt_r + SID_CNT_W'(1);
      else if (rise.up_count_decrement_in && !rise.up_count_increment_in)
        up_cnt_r <= up_cnt_r - SID_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dn_cnt_r <= '0;
    else if (op_ok)
    begin
      if (rise.counters_clear_in || rise.down_count_clear_in)
        dn_cnt_r <= '0;
      else if (rise.down_count_increment_in && !rise.down_count_decrement_in)
        dn_cnt_r <= dn_cnt_r + SID_CNT_W'(1);
      else if (rise.down_count_decrement_in && !rise.down_count_increment_in)
        dn_cnt_r <= dn_cnt_r - SID_CNT_W'(1);
    end
  end

  // presser foot toggles; reset counts as lowered so that the first press brings it home
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      foot_down_r <= 1'b1;
    else if (op_ok && rise.presser_foot_toggle_in)
      foot_down_r <= !foot_down_r;
  end

  // fixed-angle park and rotation cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fa_state_r <= SID_FA_IDLE;
      fa_phase_r <= '0;
    end
    else if (!op_ok)
    begin
      fa_state_r <= fa_state_r;
      fa_phase_r <= fa_phase_r;
    end
    else
    begin
      unique case (fa_state_r)
        SID_FA_IDLE:
        begin
          fa_phase_r <= '0;
          if (rise.fixed_angle_step_in)
            fa_state_r <= SID_FA_PARKED;
        end
        SID_FA_PARKED:
        begin
          if (start_req && !(lvl.nonstitch_next_in && !lvl.needle_up_in))
            fa_state_r <= SID_FA_IDLE;
          else if (rise.fixed_angle_step_in)
            fa_phase_r <= (fa_phase_r == SID_FA_LAST_PHASE) ? 2'h0 : fa_phase_r + 2'h1;
        end
      endcase
    end
  end

  // message stays up until a start with the needle raised is accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      msg_r <= 1'b0;
    else if (start_req && fa_state_r == SID_FA_PARKED)
      msg_r <= lvl.nonstitch_next_in && !lvl.needle_up_in;
  end

  // screen jog obeys the inhibit only in the normal mode
  assign sw_jog_ok = op_ok && (!lvl.jog_inhibit_in || mode_r != SID_MODE_NORMAL);

  // command register: all outputs come straight from here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmd <= '0;
    else
    begin
      cmd.general_output_n <= fault_r ? '0 : (op_ok ? lvl.general_input_n : cmd.general_output_n);
      cmd.fault_active     <= fault_r;
      cmd.machine_halt     <= fault_r || lvl.pressure_low_in || lvl.global_inhibit_in
                              || lvl.halt_in;
      cmd.foot_down        <= foot_down_r;
      cmd.msg_active       <= msg_r;
      cmd.needle_park      <= fa_state_r == SID_FA_PARKED;
      cmd.sew_start        <= start_req && !(fa_state_r == SID_FA_PARKED
                              && lvl.nonstitch_next_in && !lvl.needle_up_in);
      cmd.home_return      <= op_ok && rise.home_return_in && !lvl.machine_running_in;
      cmd.jog_fwd_step     <= op_ok && rise.jog_forward_in;
      cmd.jog_bwd_step     <= op_ok && rise.jog_backward_in;
      cmd.table_jog_fwd    <= sw_jog_ok && wr_jog_fwd;
      cmd.table_jog_bwd    <= sw_jog_ok && wr_jog_bwd;
      cmd.needle_fwd       <= op_ok && rise.fixed_angle_step_in && fa_state_r == SID_FA_PARKED
                              && fa_phase_r != 2'h1;
      cmd.needle_rev       <= op_ok && rise.fixed_angle_step_in && fa_state_r == SID_FA_PARKED
                              && fa_phase_r == 2'h1;
      cmd.menu_key_accept  <= op_ok && rise.menu_key_press_in && !lvl.menu_key_lock_in;
    end
  end

  // axi write channel: address and data taken in either order
  assign wr_fire    = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign wr_mapped  = wr_addr_r == SID_REG_CTRL || wr_addr_r == SID_REG_JOG;
  assign wr_jog_fwd = wr_fire && wr_addr_r == SID_REG_JOG && wr_strb_r[0] && wr_data_r[SID_JOG_FWD_BIT];
  assign wr_jog_bwd = wr_fire && wr_addr_r == SID_REG_JOG && wr_strb_r[0] && wr_data_r[SID_JOG_BWD_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_r       <= 1'b0;
      wr_addr_r     <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_ok_r       <= 1'b1;
      wr_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
      aw_ok_r <= 1'b0;
    else if (!aw_ok_r && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_ok_r       <= 1'b0;
      wr_data_r    <= '0;
      wr_strb_r    <= '0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_ok_r       <= 1'b1;
      wr_data_r    <= s_axi_wdata;
      wr_strb_r    <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
      w_ok_r <= 1'b0;
    else if (!w_ok_r && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SID_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? SID_RESP_OKAY : SID_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_r <= SID_CTRL_RESET;
    else if (wr_fire && wr_addr_r == SID_REG_CTRL && wr_strb_r[0])
      mode_r <= wr_data_r[SID_MODE_LSB +: 2];
  end

  // read mux; unmapped reads return zero with an error
  always_comb
  begin
    rd_data   = '0;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      SID_REG_CTRL:   rd_data[SID_MODE_LSB +: 2] = mode_r;
      SID_REG_JOG:    rd_data = '0;
      SID_REG_STATUS: rd_data[7:0] = {fa_phase_r, fa_state_r == SID_FA_PARKED, msg_r, foot_down_r,
                                      lvl.jog_inhibit_in, lvl.global_inhibit_in, fault_r};
      SID_REG_UPCNT:  rd_data[SID_CNT_W-1:0] = up_cnt_r;
      SID_REG_DNCNT:  rd_data[SID_CNT_W-1:0] = dn_cnt_r;
      SID_REG_GPIN:   rd_data[SID_GPIO_W-1:0] = lvl.general_input_n;
      SID_REG_CODE:   rd_data = {fault_r ? SID_FAULT_CODE : 16'h0000, msg_r ? SID_MSG_CODE : 16'h0000};
      default:        rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= SID_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_mapped ? SID_RESP_OKAY : SID_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

endmodule

// ==== include/sid_pkg.sv ====
// package: constants, register map and carriers of the sewing input dispatch block
package sid_pkg;

  localparam int unsigned SID_ADDR_W   = 8;
  localparam int unsigned SID_DATA_W   = 32;
  localparam int unsigned SID_CNT_W    = 16;
  localparam int unsigned SID_GPIO_W   = 16;

  // register byte offsets
  localparam logic [7:0] SID_REG_CTRL   = 8'h00;
  localparam logic [7:0] SID_REG_JOG    = 8'h04;
  localparam logic [7:0] SID_REG_STATUS = 8'h08;
  localparam logic [7:0] SID_REG_UPCNT  = 8'h0c;
  localparam logic [7:0] SID_REG_DNCNT  = 8'h10;
  localparam logic [7:0] SID_REG_GPIN   = 8'h14;
  localparam logic [7:0] SID_REG_CODE   = 8'h18;

  // ctrl: operating mode field
  localparam int unsigned SID_MODE_LSB  = 0;
  localparam logic [1:0]  SID_MODE_NORMAL = 2'h0;
  localparam logic [1:0]  SID_CTRL_RESET  = 2'h0;
  // jog: write-one command bits
  localparam int unsigned SID_JOG_FWD_BIT = 0;
  localparam int unsigned SID_JOG_BWD_BIT = 1;

  // displayed codes
  localparam logic [15:0] SID_FAULT_CODE = 16'h3108;
  localparam logic [15:0] SID_MSG_CODE   = 16'h0020;

  localparam logic [1:0] SID_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SID_RESP_SLVERR = 2'h2;

  localparam logic [1:0] SID_FA_LAST_PHASE = 2'h2;

  typedef enum logic [0:0] {
    SID_FA_IDLE,
    SID_FA_PARKED
  } sid_fa_state_t;

  // external input lines, all active high
  typedef struct packed {
    logic                  pressure_low_in;
    logic                  global_inhibit_in;
    logic                  start_in;
    logic                  home_return_in;
    logic                  presser_foot_toggle_in;
    logic                  jog_forward_in;
    logic                  jog_backward_in;
    logic                  jog_inhibit_in;
    logic                  halt_in;
    logic                  fixed_angle_step_in;
    logic                  counters_clear_in;
    logic                  start_inhibit_in;
    logic                  up_count_clear_in;
    logic                  down_count_clear_in;
    logic                  up_count_increment_in;
    logic                  up_count_decrement_in;
    logic                  down_count_increment_in;
    logic                  down_count_decrement_in;
    logic                  menu_key_lock_in;
    logic                  menu_key_press_in;
    logic                  clamp_on_in;
    logic                  machine_running_in;
    logic                  nonstitch_next_in;
    logic                  needle_up_in;
    logic [SID_GPIO_W-1:0] general_input_n;
  } sid_pins_t;

  // commands toward the machine
  typedef struct packed {
    logic                  sew_start;
    logic                  home_return;
    logic                  foot_down;
    logic                  jog_fwd_step;
    logic                  jog_bwd_step;
    logic                  table_jog_fwd;
    logic                  table_jog_bwd;
    logic                  machine_halt;
    logic                  needle_park;
    logic                  needle_fwd;
    logic                  needle_rev;
    logic                  menu_key_accept;
    logic                  msg_active;
    logic                  fault_active;
    logic [SID_GPIO_W-1:0] general_output_n;
  } sid_cmd_t;

endpackage

// ==== sim/sid_dispatch_monitor.sv ====
// checker: port-level assertions for the sewing input dispatch block
`timescale 1ns/1ps
module sid_dispatch_monitor
  import sid_pkg::*;
(
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire sid_pins_t pins,
  input wire sid_cmd_t  cmd
);
  logic act;
  assign act = cmd.sew_start | cmd.home_return | cmd.jog_fwd_step | cmd.jog_bwd_step
             | cmd.needle_fwd | cmd.needle_rev | cmd.menu_key_accept;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_fault_hold: assert property (cmd.fault_active |=> cmd.fault_active && cmd.machine_halt)
    else $error("fault latch dropped");
  chk_fault_quiet: assert property (cmd.fault_active |-> !act)
    else $error("action while faulted");
  chk_inhibit_quiet: assert property (pins.global_inhibit_in [*4] |-> !act)
    else $error("action while inhibited");
  // all clear for four samples: the output must be the input seen three edges back
  chk_gpio_mirror: assert property (
    (!pins.global_inhibit_in && !pins.pressure_low_in && !cmd.fault_active) [*4]
    |-> cmd.general_output_n == $past(pins.general_input_n, 3)) else $error("general output mismatch");
  chk_start_gate: assert property (
    cmd.sew_start |-> $past(pins.clamp_on_in, 3) && !$past(pins.start_inhibit_in, 3))
    else $error("start passed a closed gate");
  chk_start_edge: assert property (cmd.sew_start |-> $past(pins.start_in, 3) && !$past(pins.start_in, 4))
    else $error("start pulse without input edge");
  chk_home_gate: assert property (
    cmd.home_return |-> $past(pins.home_return_in, 3) && !$past(pins.machine_running_in, 3))
    else $error("home return while running");
  chk_jog_fwd: assert property (
    cmd.jog_fwd_step |-> $past(pins.jog_forward_in, 3) && !$past(pins.jog_forward_in, 4))
    else $error("forward step without input edge");
  chk_jog_bwd: assert property (
    cmd.jog_bwd_step |-> $past(pins.jog_backward_in, 3) && !$past(pins.jog_backward_in, 4))
    else $error("backward step without input edge");
  chk_halt_level: assert property ($past(pins.halt_in, 3) |-> cmd.machine_halt)
    else $error("halt input ignored");
  chk_menu_lock: assert property (cmd.menu_key_accept |-> !$past(pins.menu_key_lock_in, 3))
    else $error("menu key taken while locked");
endmodule

bind sid_dispatch sid_dispatch_monitor sid_dispatch_monitor_i (.aclk(aclk), .aresetn(aresetn), .pins(pins), .cmd(cmd));

// ==== sim/sid_switches.sv ====
// partner model: operator switches and machine status lines
`timescale 1ns/1ps
module sid_switches
  import sid_pkg::*;
(
  input  wire logic aclk,
  output sid_pins_t pins
);
  // released switches sit at the pull-down level, so idle lines read low
  sid_pins_t pins_r = '0;
  assign pins = pins_r;
  // held for several cycles on purpose: a long press must still act once
  task automatic press(input sid_pins_t m);
    @(posedge aclk);
    pins_r <= pins_r | m;
    repeat (6) @(posedge aclk);
    pins_r <= pins_r & ~m;
    repeat (6) @(posedge aclk);
  endtask
endmodule

// ==== sim/tb_sid_dispatch.sv ====
// testbench: sewing input dispatch driven through its pins and register bus
`timescale 1ns/1ps
module tb_sid_dispatch
  import sid_pkg::*;
;
  logic        aclk = '0;
  logic        aresetn = '0;
  sid_pins_t   pins;
  sid_cmd_t    cmd;
  logic [7:0]  aw_a = '0, ar_a = '0;
  logic [31:0] w_d = '0, r_d, rd;
  logic [3:0]  w_s = '0;
  logic        aw_v = '0, w_v = '0, b_r = '0, ar_v = '0, r_r = '0;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [1:0]  b_resp, r_resp, rsp;
  logic [8:0]  pv;
  int          pc[9] = '{default: 0};
  int          ex[9] = '{default: 0};
  int          n_fail = 0;
  int          samples_checked = 0;
  sid_pins_t   ui = '{up_count_increment_in: 1'b1, default: '0};
  sid_pins_t   di = '{down_count_increment_in: 1'b1, default: '0};
  sid_pins_t   st = '{start_in: 1'b1, default: '0};
  sid_pins_t   hm = '{home_return_in: 1'b1, default: '0};
  sid_pins_t   mk = '{menu_key_press_in: 1'b1, default: '0};
  sid_pins_t   fa = '{fixed_angle_step_in: 1'b1, default: '0};

  sid_switches sid_switches_i (.aclk(aclk), .pins(pins));
  sid_dispatch sid_dispatch_i (.aclk(aclk), .aresetn(aresetn), .pins(pins), .cmd(cmd),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r));

  always #5 aclk = ~aclk;

  // pulse tally: index 8 start, 7 home, 6/5 jog, 4/3 screen jog, 2/1 needle, 0 menu
  assign pv = {cmd.sew_start, cmd.home_return, cmd.jog_fwd_step, cmd.jog_bwd_step, cmd.table_jog_fwd,
               cmd.table_jog_bwd, cmd.needle_fwd, cmd.needle_rev, cmd.menu_key_accept};
  always @(posedge aclk)
  begin
    for (int i = 0; i < 9; i++)
      if (pv[i] === 1'b1)
        pc[i]++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pchk();
    for (int i = 0; i < 9; i++)
      chk(pc[i], ex[i]);
  endtask

  // one press, then every pulse tally must match; k < 0 means no pulse expected
  task automatic act(input sid_pins_t m, input int k);
    sid_switches_i.press(m);
    if (k >= 0)
      ex[k]++;
    pchk();
  endtask

  // one idle edge first, so bready is never lowered and raised in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    w_s <= 4'hf;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (aw_rdy && aw_v)
        aw_v <= 1'b0;
      if (w_rdy && w_v)
        w_v <= 1'b0;
    end while (b_v !== 1'b1);
    rsp = b_resp;
    b_r <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (ar_rdy && ar_v)
        ar_v <= 1'b0;
    end while (r_v !== 1'b1);
    rd = r_d;
    rsp = r_resp;
    r_r <= 1'b0;
    chk(rd, e);
  endtask

  task automatic lvl();
    repeat (5) @(posedge aclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(SID_REG_CTRL, 32'h0);
    rchk(8'h40, 32'h0);
    chk(rsp, SID_RESP_SLVERR);
    repeat (3) act(ui, -1);
    act('{up_count_decrement_in: 1'b1, default: '0}, -1);
    repeat (2) act(di, -1);
    act('{down_count_decrement_in: 1'b1, default: '0}, -1);
    rchk(SID_REG_UPCNT, 32'h2);
    rchk(SID_REG_DNCNT, 32'h1);
    act('{up_count_clear_in: 1'b1, default: '0}, -1);
    rchk(SID_REG_UPCNT, 32'h0);
    rchk(SID_REG_DNCNT, 32'h1);
    act(ui, -1);
    act('{down_count_clear_in: 1'b1, default: '0}, -1);
    rchk(SID_REG_DNCNT, 32'h0);
    rchk(SID_REG_UPCNT, 32'h1);
    act(di, -1);
    act('{counters_clear_in: 1'b1, default: '0}, -1);
    rchk(SID_REG_UPCNT, 32'h0);
    rchk(SID_REG_DNCNT, 32'h0);
    sid_switches_i.pins_r.general_input_n <= 16'ha5c3;
    lvl();
    chk(cmd.general_output_n, 32'ha5c3);
    rchk(SID_REG_GPIN, 32'ha5c3);
    act(st, -1);
    sid_switches_i.pins_r.clamp_on_in <= 1'b1;
    act(st, 8);
    sid_switches_i.pins_r.start_inhibit_in <= 1'b1;
    act(st, -1);
    sid_switches_i.pins_r.start_inhibit_in <= 1'b0;
    sid_switches_i.pins_r.machine_running_in <= 1'b1;
    act(hm, -1);
    sid_switches_i.pins_r.machine_running_in <= 1'b0;
    act(hm, 7);
    for (int i = 0; i < 3; i++)
    begin
      act('{presser_foot_toggle_in: 1'b1, default: '0}, -1);
      chk(cmd.foot_down, 32'(i % 2));
    end
    act('{jog_forward_in: 1'b1, default: '0}, 6);
    act('{jog_backward_in: 1'b1, default: '0}, 5);
    sid_switches_i.pins_r.jog_inhibit_in <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(SID_REG_CTRL, 32'(m));
      wr(SID_REG_JOG, 32'h1);
      repeat (4) @(posedge aclk);
      ex[4] += (m != 0);
      pchk();
    end
    rchk(SID_REG_CTRL, 32'h3);
    sid_switches_i.pins_r.jog_inhibit_in <= 1'b0;
    wr(SID_REG_CTRL, 32'h0);
    chk(rsp, SID_RESP_OKAY);
    wr(SID_REG_JOG, 32'h2);
    repeat (4) @(posedge aclk);
    ex[3]++;
    pchk();
    sid_switches_i.pins_r.halt_in <= 1'b1;
    lvl();
    chk(cmd.machine_halt, 32'h1);
    sid_switches_i.pins_r.halt_in <= 1'b0;
    lvl();
    chk(cmd.machine_halt, 32'h0);
    act(mk, 0);
    sid_switches_i.pins_r.menu_key_lock_in <= 1'b1;
    act(mk, -1);
    sid_switches_i.pins_r.menu_key_lock_in <= 1'b0;
    sid_switches_i.pins_r.global_inhibit_in <= 1'b1;
    act(ui | st, -1);
    rchk(SID_REG_UPCNT, 32'h0);
    sid_switches_i.pins_r.global_inhibit_in <= 1'b0;
    act(fa, -1);
    chk(cmd.needle_park, 32'h1);
    act(fa, 2);
    act(fa, 1);
    act(fa, 2);
    sid_switches_i.pins_r.nonstitch_next_in <= 1'b1;
    act(st, -1);
    chk(cmd.msg_active, 32'h1);
    rchk(SID_REG_CODE, {16'h0, SID_MSG_CODE});
    // operator raises the needle before starting again
    sid_switches_i.pins_r.needle_up_in <= 1'b1;
    act(st, 8);
    chk({cmd.needle_park, cmd.msg_active}, 32'h0);
    sid_switches_i.pins_r.pressure_low_in <= 1'b1;
    lvl();
    sid_switches_i.pins_r.pressure_low_in <= 1'b0;
    act(st, -1);
    chk({cmd.fault_active, cmd.machine_halt}, 32'h3);
    chk(cmd.general_output_n, 32'h0);
    rchk(SID_REG_CODE, {SID_FAULT_CODE, 16'h0});
    rchk(SID_REG_STATUS, 32'h1);
    wr(8'h40, 32'h0);
    chk(rsp, SID_RESP_SLVERR);
    // only a fresh power-up releases the fault latch
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(cmd.fault_active, 32'h0);
    end_of_test();
  end

  // the tests need under 600 cycles; over thirty times that means a hang
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end
endmodule
